// ==== hdl/serial_port_pkg.sv ====
// shared constants and state types for the serial register port
package serial_port_pkg;

    // byte and register address widths
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;

    // fixed upper six bits of the seven-bit i2c slave address
    localparam logic [5:0] I2C_ADDR_FIXED = 6'h3B;
    // rw bit value that selects a read
    localparam logic RW_READ = 1'h1;

    // i2c bit counter marks: eight data bits seen, and master ack bit seen
    localparam logic [3:0] I2C_BIT_LAST = 4'h8;
    localparam logic [3:0] I2C_MACK_SEEN = 4'h9;

    // spi bit counter value on the last bit of a byte, and on the first
    localparam logic [2:0] SPI_BIT_LAST = 3'h7;
    localparam logic [2:0] SPI_BIT_FIRST = 3'h0;
    // spi carries only seven address bits; the top bit is filled with this
    localparam logic SPI_ADDR_MSB = 1'h0;

    // i2c engine states
    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_RX,
        I2C_ACK,
        I2C_TX,
        I2C_MACK
    } i2c_state_type;

    // meaning of the next byte the i2c master writes
    typedef enum logic [1:0] {
        KIND_ADDR,
        KIND_PTR,
        KIND_DATA
    } byte_kind_type;

endpackage

// ==== hdl/sensor_serial_register_port.sv ====
// serial register port: i2c slave (system clock) and spi slave (serial clock)
module sensor_serial_register_port (
    // system clock and power-on reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // serial clock (spi link clock, i2c clock) and chip select
    input wire logic sck_in,
    input wire logic csb_n_in,
    // data pad: spi input, three-wire data, i2c data
    input wire logic sdi_in,
    output logic sdi_out,
    output logic sdi_oe_out,
    // output pad: spi output, i2c address select input
    input wire logic sdo_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    // configuration from the register file
    input wire logic three_wire_select_in,
    // register file access
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [serial_port_pkg::ADDR_W-1:0] reg_addr_out,
    output logic [serial_port_pkg::BYTE_W-1:0] reg_wdata_out,
    input wire logic [serial_port_pkg::BYTE_W-1:0] reg_rdata_in,
    // status
    output logic spi_selected_out,
    output logic spi_mode11_out
);

    localparam int BW = serial_port_pkg::BYTE_W;

    // system domain synchronisers and their edge stages
    logic [1:0] scl_sync_r, sda_sync_r, csb_sync_r, asel_sync_r, mode_sync_r;
    logic [1:0] rdt_sync_r, wrt_sync_r;
    logic scl_d_r, sda_d_r, rdt_seen_r, wrt_seen_r, lock_r, mode_out_r;
    // i2c engine
    serial_port_pkg::i2c_state_type st_r;
    serial_port_pkg::byte_kind_type kind_r;
    logic [3:0] cnt_r;
    logic [BW-1:0] rx_r, tx_r, ptr_r;
    logic rw_r, i2c_oe_r, i2c_wr_r, i2c_rd_r;
    // register port
    logic reg_wr_r, reg_rd_r, rd_cap_r;
    logic [serial_port_pkg::ADDR_W-1:0] reg_addr_r;
    logic [BW-1:0] reg_wdata_r, rd_hold_r;
    // link domain
    logic [2:0] lcnt_r;
    logic [BW-2:0] lrx_r;
    logic ctrl_r, rd_mode_r, rd_tgl_r, wr_tgl_r, mode11_r;
    logic [1:0] tw_sync_r;
    logic [BW-2:0] spi_addr_r;
    logic [BW-1:0] spi_data_r, spi_tx_r;
    logic sdo_oe_r, sdi3_oe_r;

    // i2c condition decode on the synchronised lines
    wire scl_hi = scl_sync_r[1];
    wire sda_now = sda_sync_r[1];
    wire scl_rise = scl_hi & ~scl_d_r;
    wire scl_fall = ~scl_hi & scl_d_r;
    wire start_det = scl_hi & scl_d_r & ~sda_now & sda_d_r;
    wire stop_det = scl_hi & scl_d_r & sda_now & ~sda_d_r;
    wire master_not_acknowledge = sda_now;
    wire addr_match =
        (rx_r[BW-1:1] == {serial_port_pkg::I2C_ADDR_FIXED, asel_sync_r[1]});
    wire spi_rd_evt = rdt_sync_r[1] ^ rdt_seen_r;
    wire spi_wr_evt = wrt_sync_r[1] ^ wrt_seen_r;
    // frame logic clears whenever chip select is high
    wire link_rst = csb_n_in | rst_in;
    wire byte_end = (lcnt_r == serial_port_pkg::SPI_BIT_LAST);
    wire [BW-1:0] lbyte = {lrx_r, sdi_in};

    // two-flop synchronisers plus one edge stage for the i2c lines
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            scl_sync_r <= '1;
            sda_sync_r <= '1;
            csb_sync_r <= '1;
            asel_sync_r <= '0;
            mode_sync_r <= '0;
            rdt_sync_r <= '0;
            wrt_sync_r <= '0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_sync_r <= {scl_sync_r[0], sck_in};
            sda_sync_r <= {sda_sync_r[0], sdi_in};
            csb_sync_r <= {csb_sync_r[0], csb_n_in};
            asel_sync_r <= {asel_sync_r[0], sdo_in};
            mode_sync_r <= {mode_sync_r[0], mode11_r};
            rdt_sync_r <= {rdt_sync_r[0], rd_tgl_r};
            wrt_sync_r <= {wrt_sync_r[0], wr_tgl_r};
            scl_d_r <= scl_hi;
            sda_d_r <= sda_now;
        end
    end

    // i2c lockout: any low level on chip select keeps i2c off until reset
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            lock_r <= 1'b0;
            mode_out_r <= 1'b0;
        end else begin
            if (!csb_sync_r[1]) lock_r <= 1'b1;
            mode_out_r <= mode_sync_r[1];
        end
    end

    // i2c engine; a start or stop overrides any state, so repeated starts work
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || lock_r) begin
            st_r <= serial_port_pkg::I2C_IDLE;
            kind_r <= serial_port_pkg::KIND_ADDR;
            cnt_r <= '0;
            rx_r <= '0;
            tx_r <= '0;
            ptr_r <= '0;
            rw_r <= 1'b0;
            i2c_oe_r <= 1'b0;
            i2c_wr_r <= 1'b0;
            i2c_rd_r <= 1'b0;
        end else begin
            i2c_wr_r <= 1'b0;
            i2c_rd_r <= 1'b0;
            if (start_det) begin
                st_r <= serial_port_pkg::I2C_RX;
                kind_r <= serial_port_pkg::KIND_ADDR;
                cnt_r <= '0;
                i2c_oe_r <= 1'b0;
            end else if (stop_det) begin
                st_r <= serial_port_pkg::I2C_IDLE;
                i2c_oe_r <= 1'b0;
            end else begin
                case (st_r)
                    serial_port_pkg::I2C_RX: begin
                        if (scl_rise) begin
                            rx_r <= {rx_r[BW-2:0], sda_now};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == serial_port_pkg::I2C_BIT_LAST) begin
                            cnt_r <= '0;
                            st_r <= serial_port_pkg::I2C_ACK;
                            i2c_oe_r <= 1'b1;
                            case (kind_r)
                                serial_port_pkg::KIND_ADDR: begin
                                    if (addr_match) begin
                                        rw_r <= rx_r[0];
                                        kind_r <= serial_port_pkg::KIND_PTR;
                                        i2c_rd_r <=
                                            (rx_r[0] == serial_port_pkg::RW_READ);
                                    end else begin
                                        st_r <= serial_port_pkg::I2C_IDLE;
                                        i2c_oe_r <= 1'b0;
                                    end
                                end
                                serial_port_pkg::KIND_PTR: begin
                                    ptr_r <= rx_r;
                                    kind_r <= serial_port_pkg::KIND_DATA;
                                end
                                default: begin
                                    i2c_wr_r <= 1'b1;
                                    kind_r <= serial_port_pkg::KIND_PTR;
                                end
                            endcase
                        end
                    end
                    serial_port_pkg::I2C_ACK: begin
                        if (scl_fall) begin
                            st_r <= rw_r ? serial_port_pkg::I2C_TX : serial_port_pkg::I2C_RX;
                            i2c_oe_r <= rw_r & ~tx_r[BW-1];
                        end
                    end
                    serial_port_pkg::I2C_TX: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == serial_port_pkg::I2C_BIT_LAST) begin
                                st_r <= serial_port_pkg::I2C_MACK;
                                i2c_oe_r <= 1'b0;
                                cnt_r <= '0;
                            end else begin
                                tx_r <= {tx_r[BW-2:0], 1'b0};
                                i2c_oe_r <= ~tx_r[BW-2];
                            end
                        end
                    end
                    serial_port_pkg::I2C_MACK: begin
                        if (scl_rise) begin
                            if (master_not_acknowledge) begin
                                st_r <= serial_port_pkg::I2C_IDLE;
                            end else begin
                                i2c_rd_r <= 1'b1;
                                cnt_r <= serial_port_pkg::I2C_MACK_SEEN;
                            end
                        end else if (scl_fall && cnt_r == serial_port_pkg::I2C_MACK_SEEN) begin
                            st_r <= serial_port_pkg::I2C_TX;
                            cnt_r <= '0;
                            i2c_oe_r <= ~tx_r[BW-1];
                        end
                    end
                    default: ;
                endcase
            end
            // read pointer moves on once per fetched byte
            if (i2c_rd_r) ptr_r <= ptr_r + 8'h01;
            if (rd_cap_r) tx_r <= reg_rdata_in;
        end
    end

    // register port shared by both protocols; they never run together
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            reg_wr_r <= 1'b0;
            reg_rd_r <= 1'b0;
            reg_addr_r <= '0;
            reg_wdata_r <= '0;
            rd_cap_r <= 1'b0;
            rd_hold_r <= '0;
            rdt_seen_r <= 1'b0;
            wrt_seen_r <= 1'b0;
        end else begin
            rdt_seen_r <= rdt_sync_r[1];
            wrt_seen_r <= wrt_sync_r[1];
            reg_wr_r <= i2c_wr_r | spi_wr_evt;
            reg_rd_r <= i2c_rd_r | spi_rd_evt;
            if (i2c_wr_r || i2c_rd_r) reg_addr_r <= ptr_r;
            else if (spi_wr_evt || spi_rd_evt)
                reg_addr_r <= {serial_port_pkg::SPI_ADDR_MSB, spi_addr_r};
            if (i2c_wr_r) reg_wdata_r <= rx_r;
            else if (spi_wr_evt) reg_wdata_r <= spi_data_r;
            rd_cap_r <= reg_rd_r;
            if (rd_cap_r) rd_hold_r <= reg_rdata_in;
        end
    end

    // spi mode taken from the serial clock level as chip select falls
    always_ff @(negedge csb_n_in or posedge rst_in) begin
        if (rst_in) mode11_r <= 1'b0;
        else mode11_r <= sck_in;
    end

    // link side: three-wire select synchroniser, a static level
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) tw_sync_r <= '0;
        else tw_sync_r <= {tw_sync_r[0], three_wire_select_in};
    end

    // link side byte framing; cleared by chip select high
    always_ff @(posedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            lcnt_r <= '0;
            lrx_r <= '0;
            ctrl_r <= 1'b1;
            rd_mode_r <= 1'b0;
        end else begin
            lrx_r <= lbyte[BW-2:0];
            lcnt_r <= lcnt_r + 3'h1;
            if (byte_end && ctrl_r) begin
                ctrl_r <= 1'b0;
                rd_mode_r <= lbyte[BW-1];
            end else if (byte_end && !rd_mode_r) begin
                ctrl_r <= 1'b1;
            end
        end
    end

    // link side requests; toggles survive frames so they never jump on csb
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            spi_addr_r <= '0;
            spi_data_r <= '0;
            rd_tgl_r <= 1'b0;
            wr_tgl_r <= 1'b0;
        end else if (!csb_n_in) begin
            if (byte_end && ctrl_r) begin
                spi_addr_r <= lbyte[BW-2:0];
                if (lbyte[BW-1]) rd_tgl_r <= ~rd_tgl_r;
            end else if (byte_end && !rd_mode_r) begin
                spi_data_r <= lbyte;
                wr_tgl_r <= ~wr_tgl_r;
            end else if (rd_mode_r && lcnt_r == serial_port_pkg::SPI_BIT_FIRST) begin
                spi_addr_r <= spi_addr_r + 7'h01;
                rd_tgl_r <= ~rd_tgl_r;
            end
        end
    end

    // link side output on falling clock; hold word is stable by the read spacing
    always_ff @(negedge sck_in or posedge link_rst) begin
        if (link_rst) begin
            spi_tx_r <= '0;
            sdo_oe_r <= 1'b0;
            sdi3_oe_r <= 1'b0;
        end else begin
            if (rd_mode_r && lcnt_r == serial_port_pkg::SPI_BIT_FIRST)
                spi_tx_r <= rd_hold_r;
            else
                spi_tx_r <= {spi_tx_r[BW-2:0], 1'b0};
            sdo_oe_r <= rd_mode_r & ~tw_sync_r[1];
            sdi3_oe_r <= rd_mode_r & tw_sync_r[1];
        end
    end

    // pads: spi shifter idles low, which is also the i2c open-drain level
    assign sdo_out = spi_tx_r[BW-1];
    assign sdo_oe_out = sdo_oe_r;
    assign sdi_out = spi_tx_r[BW-1];
    // only one of the two enables can be set: spi use locks i2c out
    assign sdi_oe_out = i2c_oe_r | sdi3_oe_r;
    assign reg_wr_out = reg_wr_r;
    assign reg_rd_out = reg_rd_r;
    assign reg_addr_out = reg_addr_r;
    assign reg_wdata_out = reg_wdata_r;
    assign spi_selected_out = lock_r;
    assign spi_mode11_out = mode_out_r;

endmodule

// ==== tb/sensor_port_chk.sv ====
// checker for the serial register port, bound to its top module
module sensor_port_chk (
    // clock, reset and pins
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic csb_n_in,
    input wire logic three_wire_select_in,
    // pad enables and status
    input wire logic sdi_oe_out,
    input wire logic sdo_oe_out,
    input wire logic spi_selected_out,
    input wire logic spi_mode11_out,
    // register side
    input wire logic reg_wr_out,
    input wire logic reg_rd_out,
    input wire logic [serial_port_pkg::ADDR_W-1:0] reg_addr_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // three wire select must be settled a while before the pad is judged
    chk_tw_sdo_idle:
        assert property (three_wire_select_in && $past(three_wire_select_in, 8) |-> !sdo_oe_out)
        else $error("output pad driven in three wire mode");
    chk_pads_exclusive:
        assert property (sdo_oe_out |-> !sdi_oe_out)
        else $error("both data pads driven");
    chk_lock_sticky:
        assert property (spi_selected_out |=> spi_selected_out)
        else $error("spi lock cleared without reset");
    chk_lock_sets:
        assert property ($fell(csb_n_in) |-> ##[1:6] spi_selected_out)
        else $error("chip select low did not lock spi");
    chk_i2c_silent:
        assert property (spi_selected_out && csb_n_in && $past(csb_n_in, 2) |-> !sdi_oe_out)
        else $error("data pad driven after spi lock");
    chk_frame_bound:
        assert property (csb_n_in && $past(csb_n_in) |-> !sdo_oe_out)
        else $error("output pad driven outside a frame");
    chk_spi_addr7:
        assert property ((reg_wr_out || reg_rd_out) && spi_selected_out |-> !reg_addr_out[7])
        else $error("spi access with address bit seven set");
    chk_rd_spacing:
        assert property (reg_rd_out |=> !reg_rd_out && !reg_wr_out)
        else $error("register read pulse too long");
    // mode flag must match the clock level seen at the select fall
    chk_mode_follows:
        assert property ($fell(csb_n_in) |-> ##6 (spi_mode11_out == $past(sck_in, 6)))
        else $error("spi mode flag wrong");
endmodule

bind sensor_serial_register_port sensor_port_chk i_sensor_port_chk (
    .clk_sys_in, .rst_in, .sck_in, .csb_n_in, .three_wire_select_in, .sdi_oe_out,
    .sdo_oe_out, .spi_selected_out, .spi_mode11_out, .reg_wr_out, .reg_rd_out, .reg_addr_out
);

// ==== tb/host_model.sv ====
// host master model: serial clock, chip select and data for i2c or spi
module host_model (
    // pins driven by the host
    output logic sck_out,
    output logic csb_n_out,
    output logic d_out,
    output logic d_oe_out,
    // resolved pad levels
    input wire logic sdi_line_in,
    input wire logic sdo_line_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: clock high, select high, data released to the pull-up
    initial begin
        sck_out = 1'b1;
        csb_n_out = 1'b1;
        d_out = 1'b0;
        d_oe_out = 1'b0;
    end
    // odd offset keeps serial edges off the system clock edges
    task automatic i2c_start();
        d_oe_out = 1'b0;
        #207 sck_out = 1'b1;
        #400 d_oe_out = 1'b1;
        d_out = 1'b0;
        #400 sck_out = 1'b0;
    endtask
    task automatic i2c_stop();
        #100 d_oe_out = 1'b1;
        #300 sck_out = 1'b1;
        #400 d_oe_out = 1'b0;
        #400;
    endtask
    // open drain: only ever pulls low
    task automatic i2c_bit(input logic b, output logic r);
        #100 d_oe_out = !b;
        #300 sck_out = 1'b1;
        r = sdi_line_in;
        #400 sck_out = 1'b0;
    endtask
    // msb first, then the ninth bit; mack pulls it low on reads
    task automatic i2c_byte(input logic [7:0] tx, input logic mack,
            output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
        i2c_bit(!mack, ack);
        ack = !ack;
    endtask
    // clock parked at its idle level while select moves
    task automatic spi_select(input logic idle);
        #7 sck_out = idle;
        #48 csb_n_out = 1'b0;
        #48;
    endtask
    task automatic spi_deselect(input logic idle);
        sck_out = idle;
        #48 csb_n_out = 1'b1;
        d_oe_out = 1'b0;
        #96;
    endtask
    // data set while clock low, taken at the rise; long pause lets reads fetch
    task automatic spi_byte(input logic [7:0] tx, input logic drv, input logic tw,
            output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck_out = 1'b0;
            d_out = tx[i];
            d_oe_out = drv;
            #24 sck_out = 1'b1;
            rx[i] = tw ? sdi_line_in : sdo_line_in;
            #24;
        end
        #400;
    endtask
endmodule

// ==== tb/tb_top.sv ====
// testbench top: host model, register file stand-in and scenarios
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic tw = 1'b0;
    logic asel = 1'b1;
    logic [7:0] rdata = 8'h00;
    wire sck, csb_n, hd, hoe, sdi_o, sdi_oe, sdo_o, sdo_oe, wr, rd, sel, m11;
    wire [7:0] addr, wdata;
    wire sdi_w, sdo_w;
    logic [15:0] wq[$];
    int bad_count = 0;
    int tests_run = 0;

    // open-drain data pad with pull-up; output pad doubles as address select
    assign sdi_w = (sdi_oe ? sdi_o : 1'b1) & (hoe ? hd : 1'b1);
    assign sdo_w = sdo_oe ? sdo_o : asel;

    sensor_serial_register_port i_sensor_serial_register_port (
        .clk_sys_in(clk), .rst_in(rst), .sck_in(sck), .csb_n_in(csb_n), .sdi_in(sdi_w),
        .sdi_out(sdi_o), .sdi_oe_out(sdi_oe), .sdo_in(sdo_w), .sdo_out(sdo_o),
        .sdo_oe_out(sdo_oe), .three_wire_select_in(tw), .reg_wr_out(wr), .reg_rd_out(rd),
        .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_rdata_in(rdata),
        .spi_selected_out(sel), .spi_mode11_out(m11));
    host_model i_host_model (.sck_out(sck), .csb_n_out(csb_n), .d_out(hd), .d_oe_out(hoe),
        .sdi_line_in(sdi_w), .sdo_line_in(sdo_w));

    initial begin
        forever #20 clk = !clk;
    end
    // register file: read data valid one cycle only, garbled otherwise
    always @(posedge clk) begin
        if (wr) wq.push_back({addr, wdata});
        rdata <= rd ? (addr ^ 8'h5A) : ~rdata;
    end

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic expect_wr(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] v = wq.size() ? wq.pop_front() : 16'hXXXX;
        cmp_byte(v[15:8], a);
        cmp_byte(v[7:0], d);
    endtask
    task automatic send_acked(input logic [7:0] b);
        logic [7:0] r;
        logic a;
        i_host_model.i2c_byte(b, 1'b0, r, a);
        cmp_bit(a, 1'b1);
    endtask

    task automatic t_i2c_write();
        @(posedge clk);
        asel <= 1'b1;
        #1000 i_host_model.i2c_start();
        send_acked(8'hEE);
        send_acked(8'h10);
        send_acked(8'h3C);
        send_acked(8'h11);
        send_acked(8'hC3);
        i_host_model.i2c_stop();
        expect_wr(8'h10, 8'h3C);
        expect_wr(8'h11, 8'hC3);
    endtask
    // select pin high, so the low-pin address must be ignored
    task automatic t_i2c_nomatch();
        logic [7:0] r;
        logic a;
        i_host_model.i2c_start();
        i_host_model.i2c_byte(8'hEC, 1'b0, r, a);
        cmp_bit(a, 1'b0);
        i_host_model.i2c_stop();
        cmp_byte(8'(wq.size()), 8'h00);
    endtask
    task automatic t_i2c_read();
        logic [7:0] r;
        logic a;
        @(posedge clk);
        asel <= 1'b0;
        #1000 i_host_model.i2c_start();
        send_acked(8'hEC);
        send_acked(8'h20);
        i_host_model.i2c_start();
        send_acked(8'hED);
        i_host_model.i2c_byte(8'hFF, 1'b1, r, a);
        cmp_byte(r, 8'h7A);
        i_host_model.i2c_byte(8'hFF, 1'b0, r, a);
        cmp_byte(r, 8'h7B);
        i_host_model.i2c_stop();
    endtask
    // a bare select pulse, no clock, must shut the i2c side off
    task automatic t_spi_lock();
        logic [7:0] r;
        logic a;
        cmp_bit(sel, 1'b0);
        i_host_model.spi_select(1'b1);
        i_host_model.spi_deselect(1'b1);
        repeat (8) @(negedge clk);
        cmp_bit(sel, 1'b1);
        i_host_model.i2c_start();
        i_host_model.i2c_byte(8'hEC, 1'b0, r, a);
        cmp_bit(a, 1'b0);
        i_host_model.i2c_stop();
    endtask
    task automatic t_spi_write();
        logic [7:0] r;
        i_host_model.spi_select(1'b0);
        i_host_model.spi_byte(8'h74, 1'b1, 1'b0, r);
        i_host_model.spi_byte(8'h55, 1'b1, 1'b0, r);
        i_host_model.spi_byte(8'h75, 1'b1, 1'b0, r);
        i_host_model.spi_byte(8'hAA, 1'b1, 1'b0, r);
        i_host_model.spi_byte(8'h33, 1'b1, 1'b0, r);
        i_host_model.spi_deselect(1'b0);
        cmp_bit(m11, 1'b0);
        expect_wr(8'h74, 8'h55);
        expect_wr(8'h75, 8'hAA);
        cmp_byte(8'(wq.size()), 8'h00);
    endtask
    // control byte then two data bytes from successive addresses
    task automatic spi_read(input logic idle, input logic three, input logic [7:0] ctrl);
        logic [7:0] r;
        @(posedge clk);
        tw <= three;
        i_host_model.spi_select(idle);
        i_host_model.spi_byte(ctrl, 1'b1, three, r);
        for (int k = 0; k < 2; k++) begin
            i_host_model.spi_byte(8'hFF, !three, three, r);
            cmp_byte(r, {1'b0, ctrl[6:0] + 7'(k)} ^ 8'h5A);
        end
        i_host_model.spi_deselect(idle);
        cmp_bit(m11, idle);
    endtask
    task automatic t_spi_read11();
        spi_read(1'b1, 1'b0, 8'hF7);
    endtask
    task automatic t_spi_read3w();
        spi_read(1'b0, 1'b1, 8'h8A);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    initial begin
        #1000000;
        bad_count++;
        $display("Error at %0t: run timed out", $time);
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        t_i2c_write();
        t_i2c_nomatch();
        t_i2c_read();
        t_spi_lock();
        t_spi_write();
        t_spi_read11();
        t_spi_read3w();
        wrap_up();
    end
endmodule
